/* File: wcs_pkg.sv */
// Purpose: shared constants and types for the word clock sync and select block
// Assumes: core clock of 200 MHz; word clock rates from 32 kHz to 96 kHz
// Notes:   register offsets are byte addresses on a 32-bit register port
package wcs_pkg;

   localparam int unsigned CLK_HZ     = 200_000_000;
   localparam int unsigned PER_W      = 14;

   // nominal word clock periods in core cycles
   localparam logic [PER_W-1:0] PER_32 = PER_W'(CLK_HZ / 32_000);
   localparam logic [PER_W-1:0] PER_44 = PER_W'(CLK_HZ / 44_100);
   localparam logic [PER_W-1:0] PER_48 = PER_W'(CLK_HZ / 48_000);
   localparam logic [PER_W-1:0] PER_64 = PER_W'(CLK_HZ / 64_000);
   localparam logic [PER_W-1:0] PER_88 = PER_W'(CLK_HZ / 88_200);
   localparam logic [PER_W-1:0] PER_96 = PER_W'(CLK_HZ / 96_000);

   // decision points halfway between neighbouring standard periods
   localparam logic [PER_W-1:0] MID_96_88 = PER_W'((CLK_HZ / 96_000 + CLK_HZ / 88_200) / 2);
   localparam logic [PER_W-1:0] MID_88_64 = PER_W'((CLK_HZ / 88_200 + CLK_HZ / 64_000) / 2);
   localparam logic [PER_W-1:0] MID_64_48 = PER_W'((CLK_HZ / 64_000 + CLK_HZ / 48_000) / 2);
   localparam logic [PER_W-1:0] MID_48_44 = PER_W'((CLK_HZ / 48_000 + CLK_HZ / 44_100) / 2);
   localparam logic [PER_W-1:0] MID_44_32 = PER_W'((CLK_HZ / 44_100 + CLK_HZ / 32_000) / 2);

   // accepted period windows, single speed and double speed
   localparam logic [PER_W-1:0] PER_LO_SS = PER_W'(CLK_HZ / 49_500);
   localparam logic [PER_W-1:0] PER_HI_SS = PER_W'(CLK_HZ / 31_000);
   localparam logic [PER_W-1:0] PER_LO_DS = PER_W'(CLK_HZ / 99_000);
   localparam logic [PER_W-1:0] PER_HI_DS = PER_W'(CLK_HZ / 62_000);

   localparam logic [2:0]       VALID_RUNS  = 3'h4;
   localparam int unsigned      TIMEOUT_US  = 64;
   localparam int unsigned      TIMEOUT_CYC = TIMEOUT_US * (CLK_HZ / 1_000_000);

   // register map
   localparam logic [7:0] REG_CTRL     = 8'h00;
   localparam logic [7:0] REG_RATE     = 8'h04;
   localparam logic [7:0] REG_STATUS   = 8'h08;
   localparam logic [7:0] REG_FREQ     = 8'h0C;
   localparam logic [7:0] REG_IRQ_STAT = 8'h10;
   localparam logic [7:0] REG_IRQ_CLR  = 8'h14;
   localparam logic [7:0] REG_IRQ_EN   = 8'h18;

   localparam int unsigned CTRL_AUTO    = 0;
   localparam int unsigned CTRL_PREF_WC = 1;
   localparam int unsigned CTRL_SINGLE  = 2;
   localparam logic [2:0]  CTRL_RST     = 3'h0;

   localparam int unsigned ST_LOCK      = 0;
   localparam int unsigned ST_SRC_WC    = 1;
   localparam int unsigned ST_SLAVE     = 2;
   localparam int unsigned ST_DOUBLE    = 3;
   localparam int unsigned ST_RATE_LSB  = 4;

   localparam int unsigned IRQ_LOCK     = 0;
   localparam int unsigned IRQ_LOST     = 1;
   localparam logic [1:0]  IRQ_RST      = 2'h0;

   typedef enum logic [2:0] {R32, R44, R48, R64, R88, R96} rate_t;
   typedef enum logic {MODE_MASTER, MODE_SLAVE} mode_t;

   localparam rate_t RATE_RST = R48;

endpackage : wcs_pkg

/* File: wck_period_meter.sv */
// Purpose: synchronise the word clock pin, time its periods and judge validity
// Assumes: word clock input is asynchronous to core_clk_i
// Notes:   validity needs VALID_RUNS good periods in a row; silence clears it
`timescale 1ns/10ps
module wck_period_meter
   import wcs_pkg::*;
#(
   parameter int unsigned TIMEOUT = TIMEOUT_CYC
) (
   // clock and reset
   input  wire logic             core_clk_i,
   input  wire logic             rst_i,
   // word clock pin
   input  wire logic             wck_in_i,
   // measurement
   output logic                  wck_lvl_o,
   output logic                  wck_rise_o,
   output logic [PER_W-1:0]      period_o,
   output logic                  valid_o
);

   localparam logic [PER_W-1:0] TMO = PER_W'(TIMEOUT);

   logic             sync1_ff, sync2_ff, prev_ff;
   logic [PER_W-1:0] cnt_ff, period_ff;
   logic [2:0]       runs_ff;
   logic             valid_ff;
   logic             in_range;

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         sync1_ff <= 1'b0;
         sync2_ff <= 1'b0;
         prev_ff  <= 1'b0;
      end else begin
         sync1_ff <= wck_in_i;
         sync2_ff <= sync1_ff;
         prev_ff  <= sync2_ff;
      end
   end

   assign wck_rise_o = sync2_ff & ~prev_ff;
   assign wck_lvl_o  = sync2_ff;

   // saturating count keeps a stopped input from wrapping into range again
   assign in_range = ((cnt_ff + 1'b1) >= PER_LO_SS && (cnt_ff + 1'b1) <= PER_HI_SS) ||
                     ((cnt_ff + 1'b1) >= PER_LO_DS && (cnt_ff + 1'b1) <= PER_HI_DS);

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         cnt_ff    <= '0;
         period_ff <= '0;
         runs_ff   <= '0;
         valid_ff  <= 1'b0;
      end else if (wck_rise_o) begin
         cnt_ff    <= '0;
         period_ff <= cnt_ff + 1'b1;
         if (!in_range) begin
            runs_ff  <= '0;
            valid_ff <= 1'b0;
         end else if (runs_ff + 1'b1 >= VALID_RUNS) begin
            runs_ff  <= VALID_RUNS;
            valid_ff <= 1'b1;
         end else begin
            runs_ff <= runs_ff + 1'b1;
         end
      end else if (cnt_ff >= TMO) begin
         runs_ff  <= '0;
         valid_ff <= 1'b0;
      end else begin
         cnt_ff <= cnt_ff + 1'b1;
      end
   end

   assign period_o = period_ff;
   assign valid_o  = valid_ff;

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (rst_i);

   a_period_capture: assert property (
      wck_rise_o |=> period_ff == $past(cnt_ff) + 1'b1)
      else $error("captured period does not match the edge count");

   a_valid_on_edge: assert property (
      $rose(valid_ff) |-> $past(wck_rise_o) && $past(runs_ff) == VALID_RUNS - 3'h1)
      else $error("valid rose without a full run of good periods");

   a_silence_drops: assert property (
      cnt_ff >= TMO && !wck_rise_o |=> !valid_ff)
      else $error("valid held after the input went silent");

endmodule : wck_period_meter

/* File: word_clock_sync_select.sv */
// Purpose: word clock reference selection, lock report, rate measure and output
// Assumes: core_clk_i at 200 MHz; plain register port with read data one cycle late
// Notes:   the word clock output is regenerated from the core clock in master mode
//
// The strobed register port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps

// Summary of operation
// - slave to word clock only when all enabled
// - accept single and double speed automatically
// - light lock lamp and report lock
// - report word clock as active reference
// - measure reference period, readable by software
// - word clock output running at rate, except while a slaved input is silent
// - master mode runs at software rate
// - slave output follows input frequency
// - on loss fall to master, nearest rate
// - single speed output halves double rates
module word_clock_sync_select
   import wcs_pkg::*;
#(
   parameter int unsigned TIMEOUT_CYCLES = TIMEOUT_CYC
) (
   // clock and reset
   input  wire logic        core_clk_i,
   input  wire logic        rst_i,
   // register port
   input  wire logic [7:0]  reg_addr_i,
   input  wire logic [31:0] reg_wdata_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   output logic [31:0]      reg_rdata_o,
   // word clock pins
   input  wire logic        wck_in_i,
   output logic             wck_out_o,
   // front panel and interrupt
   output logic             word_clock_lock_led_o,
   output logic             irq_o
);

   // maps a measured period to the closest standard rate
   function automatic rate_t nearest_rate(input logic [PER_W-1:0] p);
      if (p < MID_96_88) begin
         nearest_rate = R96;
      end else if (p < MID_88_64) begin
         nearest_rate = R88;
      end else if (p < MID_64_48) begin
         nearest_rate = R64;
      end else if (p < MID_48_44) begin
         nearest_rate = R48;
      end else if (p < MID_44_32) begin
         nearest_rate = R44;
      end else begin
         nearest_rate = R32;
      end
   endfunction : nearest_rate

   function automatic logic is_double(input rate_t r);
      is_double = (r == R64) || (r == R88) || (r == R96);
   endfunction : is_double

   // half period of the output, doubled when a double rate is halved
   function automatic logic [PER_W-1:0] half_cyc(input rate_t r, input logic halve);
      logic [PER_W-1:0] per;
      per = PER_48;
      unique case (r)
         R32: per = PER_32;
         R44: per = PER_44;
         R48: per = PER_48;
         R64: per = PER_64;
         R88: per = PER_88;
         R96: per = PER_96;
      endcase
      half_cyc = halve ? per : (per >> 1);
   endfunction : half_cyc

   logic             auto_ff, pref_wc_ff, single_ff;
   rate_t            rate_ff;
   mode_t            mode_ff;
   logic             lock_ff;
   logic [1:0]       irq_stat_ff, irq_en_ff;
   logic [31:0]      rdata_ff;
   logic [PER_W-1:0] div_ff;
   logic             wck_out_ff;

   logic             wck_lvl, wck_rise, valid;
   logic [PER_W-1:0] period;
   logic             want_slave, leave_slave, lost_ev, lock_ev;
   rate_t            cur_rate;
   logic             halve;
   logic [PER_W-1:0] reload;
   logic [1:0]       irq_set;
   logic [31:0]      rd_mux;

   wck_period_meter #(
      .TIMEOUT    (TIMEOUT_CYCLES)
   ) u_meter (
      .core_clk_i (core_clk_i),
      .rst_i      (rst_i),
      .wck_in_i   (wck_in_i),
      .wck_lvl_o  (wck_lvl),
      .wck_rise_o (wck_rise),
      .period_o   (period),
      .valid_o    (valid)
   );

   // control register
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         auto_ff    <= CTRL_RST[CTRL_AUTO];
         pref_wc_ff <= CTRL_RST[CTRL_PREF_WC];
         single_ff  <= CTRL_RST[CTRL_SINGLE];
      end else if (reg_wr_i && reg_addr_i == REG_CTRL) begin
         auto_ff    <= reg_wdata_i[CTRL_AUTO];
         pref_wc_ff <= reg_wdata_i[CTRL_PREF_WC];
         single_ff  <= reg_wdata_i[CTRL_SINGLE];
      end
   end

   assign want_slave  = auto_ff & pref_wc_ff & valid;
   assign leave_slave = (mode_ff == MODE_SLAVE) & ~want_slave;
   assign lost_ev     = (mode_ff == MODE_SLAVE) & ~valid;
   assign lock_ev     = valid & ~lock_ff;

   // clock mode
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         mode_ff <= MODE_MASTER;
      end else begin
         unique case (mode_ff)
            MODE_MASTER: if (want_slave) mode_ff <= MODE_SLAVE;
            MODE_SLAVE:  if (!want_slave) mode_ff <= MODE_MASTER;
         endcase
      end
   end

   // master rate: software picks it, a lost reference overrides with the
   // nearest standard rate so the output does not jump far
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         rate_ff <= RATE_RST;
      end else if (leave_slave) begin
         rate_ff <= nearest_rate(period);
      end else if (reg_wr_i && reg_addr_i == REG_RATE && reg_wdata_i[2:0] <= 3'h5) begin
         rate_ff <= rate_t'(reg_wdata_i[2:0]);
      end
   end

   // in slave mode the reported rate tracks the measured input
   assign cur_rate = (mode_ff == MODE_SLAVE) ? nearest_rate(period) : rate_ff;
   assign halve    = single_ff & is_double(cur_rate);
   assign reload   = half_cyc(rate_ff, halve) - 1'b1;

   // lock lamp
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         lock_ff <= 1'b0;
      end else begin
         lock_ff <= valid;
      end
   end

   assign word_clock_lock_led_o = lock_ff;

   // output word clock, never stopped in master mode, held in slave mode while the input is silent
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         div_ff     <= '0;
         wck_out_ff <= 1'b0;
      end else if (mode_ff == MODE_SLAVE) begin
         div_ff <= '0;
         if (halve) begin
            // toggling from the output itself keeps a mode change glitch-free
            wck_out_ff <= wck_out_ff ^ wck_rise;
         end else begin
            wck_out_ff <= wck_lvl;
         end
      end else if (div_ff == '0) begin
         div_ff     <= reload;
         wck_out_ff <= ~wck_out_ff;
      end else begin
         div_ff <= div_ff - 1'b1;
      end
   end

   assign wck_out_o = wck_out_ff;

   // interrupt status: a new event wins over a clear in the same cycle
   assign irq_set = {lost_ev, lock_ev};

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         irq_stat_ff <= IRQ_RST;
      end else if (reg_wr_i && reg_addr_i == REG_IRQ_CLR) begin
         irq_stat_ff <= (irq_stat_ff & ~reg_wdata_i[1:0]) | irq_set;
      end else begin
         irq_stat_ff <= irq_stat_ff | irq_set;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         irq_en_ff <= IRQ_RST;
      end else if (reg_wr_i && reg_addr_i == REG_IRQ_EN) begin
         irq_en_ff <= reg_wdata_i[1:0];
      end
   end

   assign irq_o = |(irq_stat_ff & irq_en_ff);

   // read mux; unmapped and write-only offsets read as zero
   always_comb begin
      rd_mux = 32'h0;
      unique case (reg_addr_i)
         REG_CTRL: begin
            rd_mux[CTRL_AUTO]    = auto_ff;
            rd_mux[CTRL_PREF_WC] = pref_wc_ff;
            rd_mux[CTRL_SINGLE]  = single_ff;
         end
         REG_RATE: begin
            rd_mux[2:0] = rate_ff;
         end
         REG_STATUS: begin
            rd_mux[ST_LOCK]                 = lock_ff;
            rd_mux[ST_SRC_WC]               = lock_ff & auto_ff;
            rd_mux[ST_SLAVE]                = (mode_ff == MODE_SLAVE);
            // the double bit is gated by the lock lamp, so speed reads as single before lock whatever period is measured
            rd_mux[ST_DOUBLE]               = lock_ff & is_double(nearest_rate(period));
            rd_mux[ST_RATE_LSB +: 3]        = cur_rate;
         end
         REG_FREQ: begin
            rd_mux[PER_W-1:0] = period;
         end
         REG_IRQ_STAT: begin
            rd_mux[1:0] = irq_stat_ff;
         end
         REG_IRQ_EN: begin
            rd_mux[1:0] = irq_en_ff;
         end
         default: begin
            rd_mux = 32'h0;
         end
      endcase
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         rdata_ff <= 32'h0;
      end else if (reg_rd_i) begin
         rdata_ff <= rd_mux;
      end else begin
         rdata_ff <= 32'h0;
      end
   end

   assign reg_rdata_o = rdata_ff;

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (rst_i);

   sequence s_ref_good;
      auto_ff && pref_wc_ff && valid;
   endsequence

   sequence s_ref_gone;
      mode_ff == MODE_SLAVE && !valid;
   endsequence

   a_slave_gate: assert property (
      $rose(mode_ff == MODE_SLAVE) |-> $past(auto_ff && pref_wc_ff && valid))
      else $error("entered slave mode without word clock selected and valid");

   a_slave_entry: assert property (
      mode_ff == MODE_MASTER ##0 s_ref_good |=> mode_ff == MODE_SLAVE)
      else $error("did not follow a valid selected word clock");

   a_lock_lamp: assert property (
      $rose(valid) |=> word_clock_lock_led_o && irq_stat_ff[IRQ_LOCK])
      else $error("lock lamp or lock event missing after valid");

   a_src_report: assert property (
      reg_rd_i && reg_addr_i == REG_STATUS && valid && lock_ff && auto_ff
      |=> reg_rdata_o[ST_SRC_WC])
      else $error("active reference not reported as word clock");

   a_fallback: assert property (
      s_ref_gone |=> mode_ff == MODE_MASTER && rate_ff == nearest_rate($past(period)))
      else $error("no fallback to master at nearest rate");

   a_master_toggle: assert property (
      mode_ff == MODE_MASTER && div_ff == '0
      |=> $changed(wck_out_ff) && div_ff == $past(reload))
      else $error("master divider did not reload and toggle");

   a_master_hold: assert property (
      mode_ff == MODE_MASTER && div_ff != '0 && $stable(mode_ff) |=> $stable(wck_out_ff))
      else $error("output toggled before the half period ran out");

   a_slave_follow: assert property (
      mode_ff == MODE_SLAVE && !halve |=> mode_ff != MODE_SLAVE || wck_out_ff == $past(wck_lvl))
      else $error("slave output does not follow the input");

   a_single_halve: assert property (
      mode_ff == MODE_SLAVE && halve && !wck_rise |=> $stable(wck_out_ff))
      else $error("halved output changed without an input rising edge");

   a_read_once: assert property (
      reg_rd_i ##1 !reg_rd_i |=> reg_rdata_o == 32'h0)
      else $error("read data stood longer than one cycle");

   a_read_idle: assert property (
      !reg_rd_i |=> reg_rdata_o == 32'h0)
      else $error("read data shown without a read strobe");

   a_lost_event: assert property (
      s_ref_gone |=> irq_stat_ff[IRQ_LOST])
      else $error("reference loss not flagged in interrupt status");

   a_lamp_drop: assert property (
      $fell(valid) |=> !word_clock_lock_led_o)
      else $error("lock lamp stayed lit after the input went invalid");

   a_lock_status: assert property (
      reg_rd_i && reg_addr_i == REG_STATUS |=> reg_rdata_o[ST_LOCK] == $past(lock_ff))
      else $error("status lock bit differs from the lock lamp");

   a_src_gated: assert property (
      reg_rd_i && reg_addr_i == REG_STATUS && !auto_ff |=> !reg_rdata_o[ST_SRC_WC])
      else $error("word clock reported as reference with automatic mode off");

   a_freq_report: assert property (
      reg_rd_i && reg_addr_i == REG_FREQ |=> reg_rdata_o[PER_W-1:0] == $past(period))
      else $error("frequency register differs from the measured period");

   a_double_report: assert property (
      reg_rd_i && reg_addr_i == REG_STATUS && lock_ff && period < MID_64_48
      |=> reg_rdata_o[ST_DOUBLE])
      else $error("double speed input not reported");

   a_rate_refuse: assert property (
      mode_ff == MODE_MASTER && !(reg_wr_i && reg_addr_i == REG_RATE) |=> $stable(rate_ff))
      else $error("master rate changed without a rate write");

   a_slave_rise: assert property (
      mode_ff == MODE_SLAVE && halve && wck_rise |=> $changed(wck_out_ff))
      else $error("halved output missed an input rising edge");

endmodule : word_clock_sync_select

/* File: wck_source.sv */
// Purpose: word clock source on the far side of the word clock input
// Assumes: half period given in ns; zero stops the source
// Notes:   a silent source holds its last level, as a master that has gone away does
`timescale 1ns/10ps
module wck_source (
   // control
   input  wire logic [15:0] half_ns_i,
   // word clock line
   output logic             wck_o
);
   initial begin
      wck_o = 1'b0;
      forever begin
         // poll while stopped so a new rate starts within 10 ns
         if (half_ns_i == 16'h0000) #10;
         else #(half_ns_i) wck_o = ~wck_o;
      end
   end
endmodule : wck_source

/* File: tb_word_clock_sync_select.sv */
// Purpose: self-checking bench for word clock sync and select
// Assumes: real word clock rates; default silence timeout of the block
// Notes:   period checks allow a few cycles for input sampling jitter
`timescale 1ns/10ps
module tb_word_clock_sync_select;
   import wcs_pkg::*;
   logic        core_clk_i  = 1'b0;
   logic        rst_i       = 1'b1;
   logic [7:0]  reg_addr_i  = 8'h00;
   logic [31:0] reg_wdata_i = 32'h0;
   logic        reg_wr_i    = 1'b0;
   logic        reg_rd_i    = 1'b0;
   logic [31:0] reg_rdata_o;
   logic        wck_in_i;
   logic        wck_out_o;
   logic        word_clock_lock_led_o;
   logic        irq_o;
   logic [15:0] half_ns     = 16'h0000;
   int          bad_count   = 0;
   int          tests_run   = 0;

   always #2.5 core_clk_i = ~core_clk_i;

   word_clock_sync_select word_clock_sync_select_inst (
      .core_clk_i           (core_clk_i),
      .rst_i                (rst_i),
      .reg_addr_i           (reg_addr_i),
      .reg_wdata_i          (reg_wdata_i),
      .reg_wr_i             (reg_wr_i),
      .reg_rd_i             (reg_rd_i),
      .reg_rdata_o          (reg_rdata_o),
      .wck_in_i             (wck_in_i),
      .wck_out_o            (wck_out_o),
      .word_clock_lock_led_o(word_clock_lock_led_o),
      .irq_o                (irq_o)
   );

   wck_source wck_source_inst (
      .half_ns_i(half_ns),
      .wck_o    (wck_in_i)
   );

   task automatic give_verdict();
      if (bad_count == 0 && tests_run > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : give_verdict

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   function automatic logic near(input int p, input int e);
      return (p >= e - 3) && (p <= e + 3);
   endfunction : near

   task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk_i);
      reg_addr_i  <= a;
      reg_wdata_i <= d;
      reg_wr_i    <= 1'b1;
      @(posedge core_clk_i);
      reg_wr_i    <= 1'b0;
      #1;
   endtask : reg_write

   task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
      @(posedge core_clk_i);
      reg_addr_i <= a;
      reg_rd_i   <= 1'b1;
      @(posedge core_clk_i);
      reg_rd_i   <= 1'b0;
      #1;
      d = reg_rdata_o;
   endtask : reg_read

   task automatic chk_reg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] d;
      reg_read(a, d);
      check(d & m, e);
   endtask : chk_reg

   task automatic set_src(input logic [15:0] h);
      @(posedge core_clk_i);
      half_ns <= h;
   endtask : set_src

   task automatic wait_lamp(input logic v, input int n);
      int i;
      for (i = 0; i < n && word_clock_lock_led_o !== v; i++) @(posedge core_clk_i);
      if (word_clock_lock_led_o !== v) begin
         bad_count++;
         give_verdict();
      end
      repeat (4) @(posedge core_clk_i);
   endtask : wait_lamp

   // edges from one output rise to the next; the first call only aligns
   task automatic next_rise(output int n);
      logic prev;
      for (n = 1; n < 20000; n++) begin
         prev = wck_out_o;
         @(posedge core_clk_i);
         #1;
         if (prev === 1'b0 && wck_out_o === 1'b1) break;
      end
      if (n >= 20000) begin
         bad_count++;
         give_verdict();
      end
   endtask : next_rise

   task automatic out_period(output int p);
      next_rise(p);
      next_rise(p);
   endtask : out_period

   task automatic t_reset();
      int p;
      chk_reg(REG_CTRL, 32'hFFFF_FFFF, 32'h0000_0000);
      chk_reg(REG_RATE, 32'hFFFF_FFFF, 32'h0000_0002);
      chk_reg(REG_STATUS, 32'hFFFF_FFFF, 32'h0000_0020);
      chk_reg(REG_IRQ_EN, 32'hFFFF_FFFF, 32'h0000_0000);
      reg_write(8'h1C, 32'h0000_0007);
      chk_reg(8'h1C, 32'hFFFF_FFFF, 32'h0000_0000);
      chk_reg(REG_IRQ_CLR, 32'hFFFF_FFFF, 32'h0000_0000);
      check(irq_o, 1'b0);
      out_period(p);
      check(near(p, int'(PER_48)), 1'b1);
   endtask : t_reset

   task automatic t_master();
      int p;
      reg_write(REG_RATE, 32'h0000_0005);
      reg_write(REG_RATE, 32'h0000_0006);
      chk_reg(REG_RATE, 32'hFFFF_FFFF, 32'h0000_0005);
      out_period(p);
      check(near(p, int'(PER_96)), 1'b1);
   endtask : t_master

   task automatic t_fast();
      reg_write(REG_CTRL, 32'h0000_0003);
      set_src(16'd80);
      repeat (3000) @(posedge core_clk_i);
      check(word_clock_lock_led_o, 1'b0);
      chk_reg(REG_STATUS, 32'h0000_0007, 32'h0000_0000);
   endtask : t_fast

   task automatic t_lock48();
      int p;
      reg_write(REG_IRQ_CLR, 32'h0000_0003);
      reg_write(REG_IRQ_EN, 32'h0000_0003);
      set_src(16'd10417);
      wait_lamp(1'b1, 40000);
      chk_reg(REG_STATUS, 32'h0000_000F, 32'h0000_0007);
      reg_read(REG_FREQ, p);
      check(near(p & 32'h3FFF, int'(PER_48)), 1'b1);
      chk_reg(REG_IRQ_STAT, 32'hFFFF_FFFF, 32'h0000_0001);
      check(irq_o, 1'b1);
      reg_write(REG_IRQ_CLR, 32'h0000_0001);
      check(irq_o, 1'b0);
      out_period(p);
      check(near(p, int'(PER_48)), 1'b1);
   endtask : t_lock48

   task automatic t_loss();
      int p;
      set_src(16'h0000);
      wait_lamp(1'b0, 20000);
      chk_reg(REG_STATUS, 32'h0000_007F, 32'h0000_0020);
      chk_reg(REG_IRQ_STAT, 32'hFFFF_FFFF, 32'h0000_0002);
      check(irq_o, 1'b1);
      reg_write(REG_IRQ_EN, 32'h0000_0000);
      check(irq_o, 1'b0);
      reg_write(REG_IRQ_CLR, 32'h0000_0002);
      chk_reg(REG_IRQ_STAT, 32'hFFFF_FFFF, 32'h0000_0000);
      out_period(p);
      check(near(p, int'(PER_48)), 1'b1);
   endtask : t_loss

   task automatic t_double();
      int p;
      reg_write(REG_CTRL, 32'h0000_0007);
      set_src(16'd5208);
      wait_lamp(1'b1, 20000);
      chk_reg(REG_STATUS, 32'h0000_000F, 32'h0000_000F);
      out_period(p);
      check(near(p, 2 * int'(PER_96)), 1'b1);
      reg_write(REG_CTRL, 32'h0000_0003);
      out_period(p);
      check(near(p, int'(PER_96)), 1'b1);
      // auto off keeps the lamp but drops the reference and the slave mode
      reg_write(REG_CTRL, 32'h0000_0000);
      chk_reg(REG_STATUS, 32'h0000_0077, 32'h0000_0051);
      chk_reg(REG_IRQ_STAT, 32'h0000_0002, 32'h0000_0000);
      out_period(p);
      check(near(p, int'(PER_96)), 1'b1);
   endtask : t_double

   initial begin
      repeat (16) @(posedge core_clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_master();
      t_fast();
      t_lock48();
      t_loss();
      t_double();
      give_verdict();
   end
endmodule : tb_word_clock_sync_select
